// *** verilog/clkss_params.svh ***
// Constants for the clock source select block: offsets, masks, fields, resets.
// Assumes an APB master with byte addresses and 32-bit data.
`ifndef CLKSS_PARAMS_SVH
`define CLKSS_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define CLKSS_OFF_PIN_MODE 8'h00
`define CLKSS_OFF_RUN_CTRL 8'h04
`define CLKSS_OFF_SUB_SEL 8'h08
`define CLKSS_OFF_SPEED_MODE 8'h0C
`define CLKSS_OFF_SYS_SEL 8'h10

// ==========================================================
// Writable bit masks, plus the read-only status bits of the system select register
`define CLKSS_MASK_PIN_MODE 8'hF7
`define CLKSS_MASK_RUN_CTRL 8'hC3
`define CLKSS_MASK_SUB_SEL 8'h01
`define CLKSS_MASK_SPEED_MODE 8'h90
`define CLKSS_MASK_SYS_SEL 8'h51
`define CLKSS_MASK_SYS_STAT 8'hA2

// ==========================================================
// Reset values
`define CLKSS_RST_PIN_MODE 8'h00
`define CLKSS_RST_RUN_CTRL 8'hC0
`define CLKSS_RST_SUB_SEL 8'h00
`define CLKSS_RST_SPEED_MODE 8'h00
`define CLKSS_RST_SYS_SEL 8'h00

// ==========================================================
// Field positions
`define CLKSS_B_MAIN_EXT 7
`define CLKSS_B_MAIN_OSC 6
`define CLKSS_B_SUB_EXT 5
`define CLKSS_B_SUB_OSC 4
`define CLKSS_B_SUB_DRV_HI 2
`define CLKSS_B_SUB_DRV_LO 1
`define CLKSS_B_MAIN_GAIN 0
`define CLKSS_B_MAIN_HALT 7
`define CLKSS_B_SUB_HALT 6
`define CLKSS_B_MID_RUN 1
`define CLKSS_B_FAST_HALT 0
`define CLKSS_B_SLOW_PICK 0
`define CLKSS_B_LP_GATE 7
`define CLKSS_B_TIMER_PICK 4
`define CLKSS_B_CPU_NOW_SUB 7
`define CLKSS_B_CPU_PICK 6
`define CLKSS_B_MAIN_NOW_EXT 5
`define CLKSS_B_MAIN_PICK 4
`define CLKSS_B_RC_NOW_MID 1
`define CLKSS_B_RC_PICK 0

`endif

// *** verilog/clkss_pkg.sv ***
// Types for the clock source select block.
// Assumes clkss_params.svh supplies the numbers.
package clkss_pkg;

  // ==========================================================
  // Modes and sources
  typedef enum logic [1:0] {PIN_PORT, PIN_XTAL, PIN_EXTCLK} clkss_pin_mode_t;
  typedef enum logic [1:0] {SRC_FAST_RC, SRC_MID_RC, SRC_EXT_FAST, SRC_SUB} clkss_cpu_src_t;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } clkss_apb_req_t;

  typedef struct packed {
    logic [7:0] pin_mode;
    logic [7:0] run_ctrl;
    logic [7:0] sub_sel;
    logic [7:0] speed_mode;
    logic [7:0] sys_sel;
  } clkss_regs_t;

endpackage

// *** verilog/clkss_apb_regs.sv ***
// APB slave and storage for the five clock control registers.
// Assumes a synchronised active-low reset and a status byte from the parent.
`timescale 1ns/1ps
`include "clkss_params.svh"

module clkss_apb_regs (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire clkss_pkg::clkss_apb_req_t req_in,
  input wire logic [7:0] sys_stat_in,
  output clkss_pkg::clkss_regs_t regs_out,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out
);

  // ==========================================================
  // Decode
  clkss_pkg::clkss_regs_t regs_q;
  logic [7:0] rd_byte;
  logic hit;
  logic access;
  logic commit;
  logic [7:0] wb;

  assign access = req_in.psel && req_in.penable;
  assign commit = access && pready_out;
  assign wb = req_in.pwdata[7:0];
  assign hit = (req_in.paddr == `CLKSS_OFF_PIN_MODE) || (req_in.paddr == `CLKSS_OFF_RUN_CTRL)
    || (req_in.paddr == `CLKSS_OFF_SUB_SEL) || (req_in.paddr == `CLKSS_OFF_SPEED_MODE)
    || (req_in.paddr == `CLKSS_OFF_SYS_SEL);
  assign rd_byte =
    (req_in.paddr == `CLKSS_OFF_PIN_MODE) ? regs_q.pin_mode :
    (req_in.paddr == `CLKSS_OFF_RUN_CTRL) ? regs_q.run_ctrl :
    (req_in.paddr == `CLKSS_OFF_SUB_SEL) ? regs_q.sub_sel :
    (req_in.paddr == `CLKSS_OFF_SPEED_MODE) ? regs_q.speed_mode :
    (req_in.paddr == `CLKSS_OFF_SYS_SEL) ? (regs_q.sys_sel | sys_stat_in) : 8'h00;
  assign regs_out = regs_q;

  // ==========================================================
  // Handshake: one wait state, answer registered
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= access && !pready_out;
      prdata_out <= (access && !pready_out && !req_in.pwrite) ?
        {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr_out <= access && !pready_out && !hit;
    end
  end

  // ==========================================================
  // Storage
  // Masked writes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      regs_q.pin_mode <= `CLKSS_RST_PIN_MODE;
      regs_q.run_ctrl <= `CLKSS_RST_RUN_CTRL;
      regs_q.sub_sel <= `CLKSS_RST_SUB_SEL;
      regs_q.speed_mode <= `CLKSS_RST_SPEED_MODE;
      regs_q.sys_sel <= `CLKSS_RST_SYS_SEL;
    end else if (commit && req_in.pwrite) begin
      if (req_in.paddr == `CLKSS_OFF_PIN_MODE) regs_q.pin_mode <= wb & `CLKSS_MASK_PIN_MODE;
      if (req_in.paddr == `CLKSS_OFF_RUN_CTRL) regs_q.run_ctrl <= wb & `CLKSS_MASK_RUN_CTRL;
      if (req_in.paddr == `CLKSS_OFF_SUB_SEL) regs_q.sub_sel <= wb & `CLKSS_MASK_SUB_SEL;
      if (req_in.paddr == `CLKSS_OFF_SPEED_MODE) regs_q.speed_mode <= wb & `CLKSS_MASK_SPEED_MODE;
      if (req_in.paddr == `CLKSS_OFF_SYS_SEL) regs_q.sys_sel <= wb & `CLKSS_MASK_SYS_SEL;
    end
  end

endmodule // clkss_apb_regs

// *** verilog/clkss_top.sv ***
// Clock source select control: pin modes, oscillator run controls, source picks.
// Assumes APB master on sys_clk_in; low_power_state_in is high in stop or halt.
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "clkss_params.svh"

module clkss_top (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic low_power_state_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output clkss_pkg::clkss_pin_mode_t main_pin_mode_out,
  output clkss_pkg::clkss_pin_mode_t sub_pin_mode_out,
  output logic main_osc_run_out,
  output logic main_ext_accept_out,
  output logic sub_osc_run_out,
  output logic sub_ext_valid_out,
  output logic fast_rc_run_out,
  output logic mid_rc_run_out,
  output logic [1:0] sub_drive_out,
  output logic main_gain_range_out,
  output logic sub_from_slow_rc_out,
  output logic timer_from_slow_rc_out,
  output logic periph_sub_supply_out,
  output logic main_from_ext_out,
  output clkss_pkg::clkss_cpu_src_t cpu_src_out
);

  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ==========================================================
  // Register file
  clkss_pkg::clkss_apb_req_t req;
  clkss_pkg::clkss_regs_t regs;
  logic [7:0] sys_stat;

  assign req = '{psel: psel_in, penable: penable_in, pwrite: pwrite_in,
    paddr: paddr_in, pwdata: pwdata_in};

  clkss_apb_regs u_regs (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_q),
    .req_in(req),
    .sys_stat_in(sys_stat),
    .regs_out(regs),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out)
  );

  // ==========================================================
  // Field decode
  function automatic clkss_pkg::clkss_pin_mode_t pin_mode_f(input logic ext_b, input logic osc_b);
    clkss_pkg::clkss_pin_mode_t m;
    m = clkss_pkg::PIN_PORT;
    if (osc_b) begin
      m = ext_b ? clkss_pkg::PIN_EXTCLK : clkss_pkg::PIN_XTAL;
    end
    return m;
  endfunction

  clkss_pkg::clkss_pin_mode_t main_mode;
  clkss_pkg::clkss_pin_mode_t sub_mode;
  clkss_pkg::clkss_cpu_src_t cpu_src;
  clkss_pkg::clkss_cpu_src_t rc_src;
  logic main_halt;
  logic sub_halt;
  logic cpu_pick;
  logic main_pick;
  logic rc_pick;
  logic lp_gate;

  assign main_mode = pin_mode_f(regs.pin_mode[`CLKSS_B_MAIN_EXT],
    regs.pin_mode[`CLKSS_B_MAIN_OSC]);
  assign sub_mode = pin_mode_f(regs.pin_mode[`CLKSS_B_SUB_EXT], regs.pin_mode[`CLKSS_B_SUB_OSC]);
  assign main_halt = regs.run_ctrl[`CLKSS_B_MAIN_HALT];
  assign sub_halt = regs.run_ctrl[`CLKSS_B_SUB_HALT];
  assign cpu_pick = regs.sys_sel[`CLKSS_B_CPU_PICK];
  assign main_pick = regs.sys_sel[`CLKSS_B_MAIN_PICK];
  assign rc_pick = regs.sys_sel[`CLKSS_B_RC_PICK];
  assign lp_gate = regs.speed_mode[`CLKSS_B_LP_GATE];
  assign rc_src = rc_pick ? clkss_pkg::SRC_MID_RC : clkss_pkg::SRC_FAST_RC;
  assign cpu_src = cpu_pick ? clkss_pkg::SRC_SUB : (main_pick ? clkss_pkg::SRC_EXT_FAST : rc_src);
  // Status readback: current sources shown in the system select register
  assign sys_stat = {cpu_pick, 1'b0, main_pick, 3'b000, rc_pick, 1'b0} & `CLKSS_MASK_SYS_STAT;

  // ==========================================================
  // Output registers
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      main_pin_mode_out <= clkss_pkg::PIN_PORT;
      sub_pin_mode_out <= clkss_pkg::PIN_PORT;
      main_osc_run_out <= 1'b0;
      main_ext_accept_out <= 1'b0;
      sub_osc_run_out <= 1'b0;
      sub_ext_valid_out <= 1'b0;
      fast_rc_run_out <= 1'b1;
      mid_rc_run_out <= 1'b0;
      sub_drive_out <= 2'h0;
      main_gain_range_out <= 1'b0;
      sub_from_slow_rc_out <= 1'b0;
      timer_from_slow_rc_out <= 1'b0;
      periph_sub_supply_out <= 1'b1;
      main_from_ext_out <= 1'b0;
      cpu_src_out <= clkss_pkg::SRC_FAST_RC;
    end else begin
      main_pin_mode_out <= main_mode;
      sub_pin_mode_out <= sub_mode;
      main_osc_run_out <= (main_mode == clkss_pkg::PIN_XTAL) && !main_halt;
      main_ext_accept_out <= (main_mode == clkss_pkg::PIN_EXTCLK) && !main_halt;
      sub_osc_run_out <= (sub_mode == clkss_pkg::PIN_XTAL) && !sub_halt;
      sub_ext_valid_out <= (sub_mode == clkss_pkg::PIN_EXTCLK) && !sub_halt;
      fast_rc_run_out <= !regs.run_ctrl[`CLKSS_B_FAST_HALT];
      mid_rc_run_out <= regs.run_ctrl[`CLKSS_B_MID_RUN];
      sub_drive_out <= {regs.pin_mode[`CLKSS_B_SUB_DRV_HI], regs.pin_mode[`CLKSS_B_SUB_DRV_LO]};
      main_gain_range_out <= regs.pin_mode[`CLKSS_B_MAIN_GAIN];
      sub_from_slow_rc_out <= regs.sub_sel[`CLKSS_B_SLOW_PICK];
      timer_from_slow_rc_out <= regs.speed_mode[`CLKSS_B_TIMER_PICK];
      periph_sub_supply_out <= !(low_power_state_in && cpu_pick && lp_gate);
      main_from_ext_out <= main_pick;
      // Fast RC selected while all picks are zero
      cpu_src_out <= cpu_src;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_q);

  sequence apb_write_s(logic [7:0] off, logic data_ok);
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == off && data_ok;
  endsequence

  main_pin_mode_a: assert property (
    apb_write_s(`CLKSS_OFF_PIN_MODE, pwdata_in[7:6] == 2'b11)
    ##2 $stable(regs.pin_mode) |-> main_pin_mode_out == clkss_pkg::PIN_EXTCLK)
    else $error("main pin mode not external clock after write");

  sub_pin_mode_a: assert property (
    apb_write_s(`CLKSS_OFF_PIN_MODE, pwdata_in[5:4] == 2'b01)
    ##2 $stable(regs.pin_mode) |-> sub_pin_mode_out == clkss_pkg::PIN_XTAL)
    else $error("sub pin mode not crystal after write");

  main_run_a: assert property (
    (main_osc_run_out || main_ext_accept_out) |-> !$past(main_halt)
      && $past(main_mode) != clkss_pkg::PIN_PORT)
    else $error("main clock runs while halted or in port mode");

  sub_run_a: assert property (
    $past(sub_mode) == clkss_pkg::PIN_XTAL && !$past(sub_halt) |-> sub_osc_run_out
      && !sub_ext_valid_out)
    else $error("sub oscillator not running when enabled");

  fast_rc_a: assert property (
    apb_write_s(`CLKSS_OFF_RUN_CTRL, pwdata_in[0]) |-> ##2 !fast_rc_run_out)
    else $error("fast RC still running after halt write");

  sub_source_a: assert property (
    sub_from_slow_rc_out == $past(regs.sub_sel[`CLKSS_B_SLOW_PICK]))
    else $error("subsystem source does not follow its select");

  lp_gate_a: assert property (
    low_power_state_in && cpu_pick && lp_gate |=> !periph_sub_supply_out)
    else $error("sub clock still supplied in gated low power");

  timer_src_a: assert property (
    apb_write_s(`CLKSS_OFF_SPEED_MODE, !pwdata_in[4]) |-> ##2 !timer_from_slow_rc_out)
    else $error("timer not on subsystem clock after write");

  cpu_source_a: assert property (
    cpu_pick [*2] |-> cpu_src_out == clkss_pkg::SRC_SUB)
    else $error("CPU not on subsystem clock");

  main_source_a: assert property (
    !$past(cpu_pick) && $past(main_pick) |-> cpu_src_out == clkss_pkg::SRC_EXT_FAST)
    else $error("CPU not on external fast clock");

  rc_speed_a: assert property (
    !$past(cpu_pick) && !$past(main_pick) |-> cpu_src_out ==
      ($past(rc_pick) ? clkss_pkg::SRC_MID_RC : clkss_pkg::SRC_FAST_RC))
    else $error("on-chip RC choice wrong");

  reset_src_a: assert property (@(posedge sys_clk_in)
    $rose(rst_n_q) |-> cpu_src_out == clkss_pkg::SRC_FAST_RC && regs.sys_sel == 8'h00)
    else $error("CPU not on fast RC after reset");

  reserved_zero_a: assert property (
    (regs.run_ctrl & ~`CLKSS_MASK_RUN_CTRL) == 8'h00
      && (regs.speed_mode & ~`CLKSS_MASK_SPEED_MODE) == 8'h00
      && (regs.sys_sel & ~`CLKSS_MASK_SYS_SEL) == 8'h00)
    else $error("unused register bits not zero");

  // ==========================================================
  // Bus handshake checks
  logic addr_mapped;

  assign addr_mapped = (paddr_in[1:0] == 2'b00) && (paddr_in <= `CLKSS_OFF_SYS_SEL);

  sequence apb_setup_s;
    psel_in && !penable_in;
  endsequence

  sequence apb_wait_s;
    psel_in && penable_in && !pready_out;
  endsequence

  sequence apb_read_s(logic [7:0] off);
    psel_in && penable_in && pready_out && !pwrite_in && paddr_in == off;
  endsequence

  ready_after_wait_a: assert property (
    apb_setup_s ##1 apb_wait_s |=> pready_out)
    else $error("ready not raised after one wait state");

  ready_pulse_a: assert property (
    pready_out |=> !pready_out)
    else $error("ready held for more than one cycle");

  error_with_ready_a: assert property (
    pslverr_out |-> pready_out)
    else $error("slave error without ready");

  unmapped_error_a: assert property (
    psel_in && penable_in && pready_out && !addr_mapped |-> pslverr_out)
    else $error("unmapped access not flagged");

  mapped_no_error_a: assert property (
    psel_in && penable_in && pready_out && addr_mapped |-> !pslverr_out)
    else $error("mapped access flagged as error");

  read_idle_zero_a: assert property (
    !pready_out |-> prdata_out == 32'h0000_0000)
    else $error("read data not zero outside a read");

  read_upper_zero_a: assert property (
    prdata_out[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  pin_read_data_a: assert property (
    apb_read_s(`CLKSS_OFF_PIN_MODE) |-> prdata_out[7:0] == $past(regs.pin_mode))
    else $error("pin mode read data wrong");

  pin_write_lands_a: assert property (
    apb_write_s(`CLKSS_OFF_PIN_MODE, 1'b1) |=>
      regs.pin_mode == ($past(pwdata_in[7:0]) & `CLKSS_MASK_PIN_MODE))
    else $error("pin mode write not stored");

  // ==========================================================
  // Reserved-bit and output follow checks
  pin_reserved_zero_a: assert property (
    (regs.pin_mode & ~`CLKSS_MASK_PIN_MODE) == 8'h00
      && (regs.sub_sel & ~`CLKSS_MASK_SUB_SEL) == 8'h00)
    else $error("unused pin or source bits not zero");

  main_code_two_a: assert property (
    $past(regs.pin_mode[`CLKSS_B_MAIN_EXT]) && !$past(regs.pin_mode[`CLKSS_B_MAIN_OSC])
      |-> main_pin_mode_out == clkss_pkg::PIN_PORT)
    else $error("main pin code two not input port");

  sub_halted_a: assert property (
    $past(sub_halt) |-> !sub_osc_run_out && !sub_ext_valid_out)
    else $error("sub clock active while halted");

  fast_rc_follow_a: assert property (
    fast_rc_run_out == !$past(regs.run_ctrl[`CLKSS_B_FAST_HALT]))
    else $error("fast RC run does not follow its halt bit");

  supply_kept_a: assert property (
    !(low_power_state_in && cpu_pick && lp_gate) |=> periph_sub_supply_out)
    else $error("sub clock supply cut without gate");

  timer_follow_a: assert property (
    timer_from_slow_rc_out == $past(regs.speed_mode[`CLKSS_B_TIMER_PICK]))
    else $error("timer source does not follow its select");

endmodule // clkss_top

// *** tb/clkss_osc_model.sv ***
// Behavioural resonator or external clock feeding the main or sub clock pins.
// Assumes run_in is the block's run or accept output for that oscillator.
`timescale 1ns/1ps

module clkss_osc_model #(
  parameter real HALF_NS = 15.0
) (
  input wire logic run_in,
  output logic clk_out
);
  // ==========================================================
  // Oscillation
  // A stopped resonator has no swing, so the pin settles low
  initial clk_out = 1'h0;
  always begin
    #(HALF_NS);
    clk_out = run_in ? ~clk_out : 1'h0;
  end
endmodule // clkss_osc_model

// *** tb/testbench.sv ***
// Self-checking bench for clkss_top: APB register accesses and source outputs.
// Assumes clkss_params.svh offsets and masks; outputs follow registers a cycle late.
`timescale 1ns/1ps
`include "clkss_params.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin miscompares++; \
  $display("FAIL %s expected %0h seen %0h", nm, ex, gt); end end

module testbench;
  logic sys_clk_in = 1'h0;
  logic rstn_in = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic lp = 1'h0;
  logic [31:0] prdata;
  logic pready, pslverr, main_osc, main_acc, sub_osc, sub_val, fast_run, mid_run;
  logic main_gain, sub_slow, timer_slow, periph_sup, main_ext, main_xclk, sub_xclk;
  logic [1:0] sub_drive;
  clkss_pkg::clkss_pin_mode_t main_pm, sub_pm;
  clkss_pkg::clkss_cpu_src_t cpu_src;
  logic [7:0] rd;
  logic err;
  int miscompares = 0;
  int check_count = 0;
  int main_edges = 0;
  int sub_edges = 0;
  logic [7:0] offs [5] = '{`CLKSS_OFF_PIN_MODE, `CLKSS_OFF_RUN_CTRL, `CLKSS_OFF_SUB_SEL,
    `CLKSS_OFF_SPEED_MODE, `CLKSS_OFF_SYS_SEL};
  logic [7:0] rsts [5] = '{`CLKSS_RST_PIN_MODE, `CLKSS_RST_RUN_CTRL, `CLKSS_RST_SUB_SEL,
    `CLKSS_RST_SPEED_MODE, `CLKSS_RST_SYS_SEL};
  logic [7:0] masks [5] = '{`CLKSS_MASK_PIN_MODE, `CLKSS_MASK_RUN_CTRL, `CLKSS_MASK_SUB_SEL,
    `CLKSS_MASK_SPEED_MODE, `CLKSS_MASK_SYS_SEL};

  always #2.5 sys_clk_in = ~sys_clk_in;

  clkss_top i_clkss_top (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .low_power_state_in(lp), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .main_pin_mode_out(main_pm), .sub_pin_mode_out(sub_pm),
    .main_osc_run_out(main_osc), .main_ext_accept_out(main_acc), .sub_osc_run_out(sub_osc),
    .sub_ext_valid_out(sub_val), .fast_rc_run_out(fast_run), .mid_rc_run_out(mid_run),
    .sub_drive_out(sub_drive), .main_gain_range_out(main_gain),
    .sub_from_slow_rc_out(sub_slow), .timer_from_slow_rc_out(timer_slow),
    .periph_sub_supply_out(periph_sup), .main_from_ext_out(main_ext), .cpu_src_out(cpu_src));
  clkss_osc_model i_clkss_osc_main (.run_in(main_osc | main_acc), .clk_out(main_xclk));
  clkss_osc_model #(.HALF_NS(61.0)) i_clkss_osc_sub (.run_in(sub_osc | sub_val),
    .clk_out(sub_xclk));
  always @(posedge main_xclk) main_edges++;
  always @(posedge sub_xclk) sub_edges++;

  // ==========================================================
  // Helpers
  function automatic clkss_pkg::clkss_pin_mode_t pm(input logic [1:0] c);
    return (c == 2'h1) ? clkss_pkg::PIN_XTAL : (c == 2'h3) ? clkss_pkg::PIN_EXTCLK :
      clkss_pkg::PIN_PORT;
  endfunction

  function automatic logic [7:0] rd_exp(input int i, input logic [7:0] w);
    if (i != 4) return w & masks[i];
    return (w & masks[4]) | {w[6], 1'h0, w[4], 3'h0, w[0], 1'h0};
  endfunction

  task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'hA5_5A00, d};
    @(posedge sys_clk_in);
    penable <= 1'h1;
    do begin
      @(posedge sys_clk_in);
    end while (pready !== 1'h1);
    rd = prdata[7:0];
    err = pslverr;
    `CHK("prdata_upper", 24'h00_0000, prdata[31:8])
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb_xfer(1'h1, a, d);
    repeat (2) @(posedge sys_clk_in);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    miscompares++;
    $display("FAIL watchdog expected done seen hang");
    complete_run();
  end

  // ==========================================================
  // Tests
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rstn_in <= 1'h1;
    repeat (5) @(posedge sys_clk_in);
    `CHK("cpu_src_reset", clkss_pkg::SRC_FAST_RC, cpu_src)
    `CHK("fast_rc_reset", 1'h1, fast_run)
    for (int i = 0; i < 5; i++) begin
      apb_xfer(1'h0, offs[i], 8'h00);
      `CHK("reset_value", rsts[i], rd)
      `CHK("mapped_err", 1'h0, err)
      wr(offs[i], 8'hFF);
      apb_xfer(1'h0, offs[i], 8'h00);
      `CHK("read_ones", rd_exp(i, 8'hFF), rd)
      wr(offs[i], 8'h00);
      apb_xfer(1'h0, offs[i], 8'h00);
      `CHK("read_zeros", rd_exp(i, 8'h00), rd)
    end
    wr(8'h14, 8'hFF);
    `CHK("unmapped_wr_err", 1'h1, err)
    apb_xfer(1'h0, 8'h14, 8'h00);
    `CHK("unmapped_rd_err", 1'h1, err)
    `CHK("unmapped_rd_data", 8'h00, rd)
    apb_xfer(1'h0, `CLKSS_OFF_PIN_MODE, 8'h00);
    `CHK("no_alias", 8'h00, rd)
    for (int c = 0; c < 4; c++) begin
      for (int h = 0; h < 2; h++) begin
        wr(`CLKSS_OFF_PIN_MODE, {c[1:0], c[1:0], 1'h0, c[1:0], h[0]});
        wr(`CLKSS_OFF_RUN_CTRL, {h[0], h[0], 4'h0, c[0], h[0]});
        `CHK("main_pin_mode", pm(c[1:0]), main_pm)
        `CHK("sub_pin_mode", pm(c[1:0]), sub_pm)
        `CHK("main_osc_run", (c == 1 && h == 0), main_osc)
        `CHK("main_ext_accept", (c == 3 && h == 0), main_acc)
        `CHK("sub_osc_run", (c == 1 && h == 0), sub_osc)
        `CHK("sub_ext_valid", (c == 3 && h == 0), sub_val)
        `CHK("fast_rc_run", ~h[0], fast_run)
        `CHK("mid_rc_run", c[0], mid_run)
        `CHK("sub_drive", c[1:0], sub_drive)
        `CHK("main_gain", h[0], main_gain)
        main_edges = 0;
        sub_edges = 0;
        repeat (30) @(posedge sys_clk_in);
        `CHK("main_clock_swing", (c[0] && h == 0), main_edges != 0)
        `CHK("sub_clock_swing", (c[0] && h == 0), sub_edges != 0)
      end
    end
    for (int j = 0; j < 8; j++) begin
      wr(`CLKSS_OFF_SYS_SEL, {1'h0, j[2], 1'h0, j[1], 3'h0, j[0]});
      `CHK("cpu_src", j[2] ? clkss_pkg::SRC_SUB : j[1] ? clkss_pkg::SRC_EXT_FAST :
        j[0] ? clkss_pkg::SRC_MID_RC : clkss_pkg::SRC_FAST_RC, cpu_src)
      `CHK("main_from_ext", j[1], main_ext)
      apb_xfer(1'h0, `CLKSS_OFF_SYS_SEL, 8'h00);
      `CHK("sys_status", rd_exp(4, {1'h0, j[2], 1'h0, j[1], 3'h0, j[0]}), rd)
      for (int k = 0; k < 4; k++) begin
        wr(`CLKSS_OFF_SPEED_MODE, {k[1], 2'h0, k[0], 4'h0});
        wr(`CLKSS_OFF_SUB_SEL, {7'h00, k[0]});
        `CHK("sub_from_slow", k[0], sub_slow)
        `CHK("timer_from_slow", k[0], timer_slow)
        lp <= 1'h1;
        repeat (3) @(posedge sys_clk_in);
        `CHK("periph_supply_lp", ~(j[2] & k[1]), periph_sup)
        lp <= 1'h0;
        repeat (3) @(posedge sys_clk_in);
        `CHK("periph_supply_run", 1'h1, periph_sup)
      end
    end
    complete_run();
  end
endmodule // testbench
